// *** i2c_expander_host_port_irq_tb.sv ***
// self-checking bench for the expander host port and interrupt
`include "io_expander_consts.vh"
module i2c_expander_host_port_irq_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DLY = 4;
  logic       clk, sys_rst, rst_pin_n, addr_pin, ack;
  logic [7:0] gpio_i, v, dir, hz, rnd;
  logic [6:0] me;
  wire        scl, sda_low, sda_o, sda_oe, int_o, int_oe;
  wire  [7:0] gpio_o, gpio_oe, pull_en, pull_sel;
  wire        sda = ~sda_low & (~sda_oe | sda_o);
  int         n_mismatch, num_checks, b, n;
  // ----------------------------------------------------------------
  // design, far-side master and clock
  // ----------------------------------------------------------------
  io_expander_port #(.DLY_CYC(DLY)) dut_u (
    .clk, .ce(1'b1), .sys_rst, .rst_pin_n, .addr_pin, .scl_i(scl), .sda_i(sda), .sda_o,
    .sda_oe, .gpio_i, .gpio_o, .gpio_oe, .pull_en, .pull_sel, .int_o, .int_oe
  );
  i2c_master_model m_u (.clk, .sda, .scl, .sda_low);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [7:0] in_view(input logic [7:0] p, input logic [7:0] d);
    return p | d;
  endfunction
  function automatic logic [7:0] drv(input logic [7:0] d, input logic [7:0] h);
    return d & ~h;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // write n bytes d, d+1, ... to register c; ack keeps the last slot
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, input int n);
    logic [7:0] r;
    m_u.start();
    m_u.xfer({a, 1'b0}, 1'b1, r, ack);
    m_u.xfer(c, 1'b1, r, ack);
    for (int k = 0; k < n; k++) m_u.xfer(d + 8'(k), 1'b1, r, ack);
    m_u.stop();
  endtask
  // a short read skips the command and relies on the kept selection
  task automatic rd(input logic [6:0] a, input logic [7:0] c, input logic full,
                    output logic [7:0] r);
    logic [7:0] x;
    if (full) begin
      m_u.start();
      m_u.xfer({a, 1'b0}, 1'b1, x, ack);
      m_u.xfer(c, 1'b1, x, ack);
    end
    m_u.start();
    m_u.xfer({a, 1'b1}, 1'b1, x, ack);
    m_u.xfer(8'hFF, 1'b1, r, x[0]);
    m_u.stop();
  endtask
  task automatic chk_dflt();
    chk(gpio_o, `RST_OUT);
    chk(gpio_oe, drv(`RST_DIR, `RST_HIZ));
    chk(pull_en, `RST_PULL_EN);
    chk(pull_sel, `RST_PULL_SEL);
    chk({7'h0, int_oe}, 8'h00);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // the sequence needs about 12000 clk; this cuts a hang short
  initial begin
    #300000;
    n_mismatch++;
    finish_test();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    rst_pin_n = 1'b1;
    gpio_i = 8'hFF;
    n_mismatch = 0;
    num_checks = 0;
    void'($urandom(32'h16E531B1));
    addr_pin = 1'($urandom);
    me = {`DEV_ADDR_BASE, addr_pin};
    cyc(6);
    sys_rst = 1'b0;
    cyc(8);
    chk_dflt();
    // random register traffic, multi-byte writes and read-back
    for (int i = 0; i < 4; i++) begin
      dir = 8'($urandom);
      hz = 8'($urandom);
      rnd = 8'($urandom);
      n = $urandom_range(4, 1);
      gpio_i = 8'($urandom);
      wr(me, `REG_DIR, dir, 1);
      wr(me, `REG_HIZ, hz, 1);
      wr(me, `REG_OUT, rnd, n);
      wr(me, `REG_PULL_EN, ~rnd, 1);
      wr(me, `REG_PULL_SEL, rnd ^ dir, 1);
      chk(gpio_o, rnd + 8'(n - 1));
      chk(gpio_oe, drv(dir, hz));
      chk(pull_en, ~rnd);
      chk(pull_sel, rnd ^ dir);
      rd(me, `REG_OUT, 1'b1, v);
      chk(v, rnd + 8'(n - 1));
      rd(me, `REG_INPUT, 1'b1, v);
      chk(v, in_view(gpio_i, dir));
      gpio_i = 8'($urandom);
      cyc(4);
      rd(me, 8'h00, 1'b0, v);
      chk(v, in_view(gpio_i, dir));
    end
    // stop inside a data byte keeps the byte before it
    m_u.start();
    m_u.xfer({me, 1'b0}, 1'b1, v, ack);
    m_u.xfer(`REG_OUT, 1'b1, v, ack);
    m_u.xfer(rnd, 1'b1, v, ack);
    for (int k = 0; k < 4; k++) m_u.bit_io(1'b1, ack);
    m_u.stop();
    cyc(2);
    chk(gpio_o, rnd);
    wr(me ^ 7'h01, `REG_OUT, ~rnd, 1);
    chk({7'h0, ack}, 8'h00);
    chk(gpio_o, rnd);
    // reset pin held far beyond its minimum, with traffic meanwhile
    gpio_i = 8'hFF;
    rst_pin_n = 1'b0;
    wr(me, `REG_OUT, 8'h3C, 1);
    chk({7'h0, ack}, 8'h00);
    chk_dflt();
    rst_pin_n = 1'b1;
    cyc(6);
    chk_dflt();
    // interrupts: masked pin, unmasked pin, foreign traffic, rearm
    wr(me, `REG_MASK, 8'h02, 1);
    gpio_i[1] = 1'b0;
    cyc(DLY + 12);
    chk({7'h0, int_oe}, 8'h00);
    rd(me, `REG_STATUS, 1'b1, v);
    chk(v, 8'h02);
    b = $urandom_range(6, 2);
    gpio_i[b] = 1'b0;
    cyc(DLY + 12);
    chk({7'h0, int_oe}, 8'h01);
    rd(me ^ 7'h01, `REG_OUT, 1'b1, v);
    chk({7'h0, int_oe}, 8'h01);
    rd(me, 8'h00, 1'b0, v);
    chk(v, 8'h01 << b);
    chk({7'h0, int_oe}, 8'h00);
    gpio_i[b] = 1'b1;
    cyc(6);
    gpio_i[b] = 1'b0;
    cyc(DLY + 12);
    chk({7'h0, int_oe}, 8'h01);
    rd(me, 8'h00, 1'b0, v);
    chk(v, 8'h01 << b);
    wr(me, `REG_DIR, 8'h01, 1);
    gpio_i[0] = 1'b0;
    cyc(DLY + 12);
    chk({7'h0, int_oe}, 8'h00);
    rd(me, `REG_STATUS, 1'b1, v);
    chk(v, 8'h00);
    // event in the data phase, after the snapshot at address ack
    fork
      rd(me, 8'h00, 1'b0, v);
      begin
        cyc(110);
        gpio_i[7] = 1'b0;
      end
    join
    chk(v, 8'h00);
    chk({7'h0, int_oe}, 8'h01);
    rd(me, 8'h00, 1'b0, v);
    chk(v, 8'h80);
    chk({7'h0, int_oe}, 8'h00);
    finish_test();
  end
endmodule // i2c_expander_host_port_irq_tb

// *** i2c_master_model.sv ***
// behavioural bus master for the expander serial port
module i2c_master_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  // released lines rest high through the pull-ups; clock stands still
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // changes land 1 ns after a clk edge so sampling never races
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one 32 ns bit cell: data set mid-low, read at the end of high
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    sda_low = ~b;
    tick(2);
    scl = 1'b1;
    tick(4);
    r   = sda;
    scl = 1'b0;
  endtask
  // start or restart: data falls while clock is high
  task automatic start();
    tick(2);
    sda_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask
  // stop: data rises while clock is high, may end a frame anywhere
  task automatic stop();
    tick(2);
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(4);
  endtask
  // byte msb first plus ninth bit; ack true when the slot was low
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r,
                      output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(mack, a);
    ack = ~a;
  endtask
endmodule // i2c_master_model

// *** io_expander_consts.vh ***
// constants shared by the expander host port and its interrupt logic
`ifndef IO_EXPANDER_CONSTS_VH
`define IO_EXPANDER_CONSTS_VH

// ----------------------------------------------------------------
// register offsets, selected by the command byte
// ----------------------------------------------------------------
`define REG_DIR      8'h03
`define REG_OUT      8'h05
`define REG_HIZ      8'h07
`define REG_DFLT     8'h09
`define REG_PULL_EN  8'h0B
`define REG_PULL_SEL 8'h0D
`define REG_INPUT    8'h0F
`define REG_MASK     8'h11
`define REG_STATUS   8'h13

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_DIR      8'h00
`define RST_OUT      8'h00
`define RST_HIZ      8'hFF
`define RST_DFLT     8'hFF
`define RST_PULL_EN  8'hFF
`define RST_PULL_SEL 8'h00
`define RST_MASK     8'h00
`define RST_STATUS   8'h00
`define RST_CMD      8'h00

// ----------------------------------------------------------------
// bus framing and timing
// ----------------------------------------------------------------
`define ACK_SLOT       4'h8
`define LAST_DATA_BIT  4'h7
`define DEV_ADDR_BASE  6'h10
`define CLK_PERIOD_NS  4
`define IRQ_VALID_DELAY_NS 1000
// longest delay: round down to whole cycles
`define IRQ_VALID_CYC (`IRQ_VALID_DELAY_NS / `CLK_PERIOD_NS)

`endif

// *** io_expander_port.v ***
// serial host port, register file and reset pin of the 8-bit expander
`include "io_expander_consts.vh"

// Function
// RULE1 - reset pin low forces all registers and bus state to defaults
// RULE2 - bus accesses take effect only while the reset pin is high
// RULE3 - the controller holds the reset pin low at least the minimum width
// RULE4 - input pin transitions raise the interrupt after the valid delay
// RULE5 - reading status clears the interrupt at the ack or nack rising edge
// RULE6 - after a clear every later input change is signalled again
// RULE7 - status is captured at the rising edge of read address ack
// RULE8 - an event near the capture may show twice but is never lost
// RULE9 - traffic to other targets leaves the interrupt state unchanged
// RULE10 - pins set as outputs never raise an interrupt
// RULE11 - switching output to input may raise a spurious interrupt
// RULE12 - interrupt output is active low open drain, pulling low only
// RULE13 - a write sends address with bit 0 low, then the command byte
// RULE14 - any number of data bytes is accepted in one write
// RULE15 - a read is address, command, restart, address with bit 0 high
// RULE16 - each data byte commits at the rising edge of its ack clock
// RULE17 - a stop may come anytime; bytes done at the last ack stay valid
// RULE18 - the command selection is kept between transactions
// RULE19 - status sets when input leaves its default; must return to rearm
// RULE20 - a masked pin still sets status but does not pull the interrupt
// RULE21 - only the own address is acknowledged; others are ignored
module io_expander_port #(
  parameter WIDTH   = 8,
  parameter DLY_CYC = `IRQ_VALID_CYC
) (
  input  wire             clk,
  input  wire             ce,
  input  wire             sys_rst,
  input  wire             rst_pin_n,
  input  wire             addr_pin,
  input  wire             scl_i,
  input  wire             sda_i,
  output reg              sda_o,
  output reg              sda_oe,
  input  wire [WIDTH-1:0] gpio_i,
  output reg  [WIDTH-1:0] gpio_o,
  output reg  [WIDTH-1:0] gpio_oe,
  output reg  [WIDTH-1:0] pull_en,
  output reg  [WIDTH-1:0] pull_sel,
  output reg              int_o,
  output wire             int_oe
);

  // ----------------------------------------------------------------
  // transfer phases
  // ----------------------------------------------------------------
  localparam PH_IDLE  = 3'h0;
  localparam PH_ADDR  = 3'h1;
  localparam PH_CMD   = 3'h2;
  localparam PH_WDATA = 3'h3;
  localparam PH_RDATA = 3'h4;

  localparam SW = WIDTH + 4;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg  [SW-1:0]    sync1_q;
  reg  [SW-1:0]    sync2_q;
  reg              scl_p_q;
  reg              sda_p_q;
  reg  [WIDTH-1:0] dir_q;
  reg  [WIDTH-1:0] out_q;
  reg  [WIDTH-1:0] hiz_q;
  reg  [WIDTH-1:0] dflt_q;
  reg  [WIDTH-1:0] pen_q;
  reg  [WIDTH-1:0] psel_q;
  reg  [WIDTH-1:0] mask_q;
  reg  [7:0]       cmd_q;
  reg  [2:0]       ph_q;
  reg  [3:0]       cnt_q;
  reg  [7:0]       sh_q;
  reg  [7:0]       tx_q;
  reg              rw_q;
  reg              nack_q;
  reg              rd_st_q;
  reg  [WIDTH-1:0] snap_q;
  reg  [WIDTH-1:0] clrb_q;
  reg              clr_q;
  wire [WIDTH-1:0] status;
  wire             rst;
  wire             scl_s;
  wire             sda_s;
  wire             addr_s;
  wire             rstn_s;
  wire [WIDTH-1:0] gpio_s;
  wire             scl_r;
  wire             scl_f;
  wire             start;
  wire             stop;
  wire [6:0]       my_addr;
  wire [WIDTH-1:0] in_stat;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // every pin, the bus clock included, is sampled by clk through two
  // stages; only the second stage is looked at
  always @(posedge clk) begin
    if (sys_rst) begin
      sync1_q <= {SW{1'b0}};
      sync2_q <= {SW{1'b0}};
    end else if (ce) begin
      sync1_q <= {rst_pin_n, addr_pin, scl_i, sda_i, gpio_i};
      sync2_q <= sync1_q;
    end
  end

  assign rstn_s = sync2_q[SW-1];
  assign addr_s = sync2_q[SW-2];
  assign scl_s  = sync2_q[SW-3];
  assign sda_s  = sync2_q[SW-4];
  assign gpio_s = sync2_q[WIDTH-1:0];

  // the reset pin acts as a synchronous reset of all block state past the pin synchronisers
  assign rst = sys_rst | ~rstn_s; // RULE1 RULE2

  // ----------------------------------------------------------------
  // bus line history and condition detection
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (ce) begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign scl_r = scl_s & ~scl_p_q;
  assign scl_f = ~scl_s & scl_p_q;
  // start and stop are sda moving while scl stays high
  assign start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // low address bit follows the address strap pin
  assign my_addr = {`DEV_ADDR_BASE, addr_s};

  // pins set as outputs read back high in the input register
  assign in_stat = gpio_s | dir_q;

  // ----------------------------------------------------------------
  // register read selection
  // ----------------------------------------------------------------
  function [7:0] rd_mux;
    input [7:0] sel;
    begin
      case (sel)
        `REG_DIR:      rd_mux = dir_q;
        `REG_OUT:      rd_mux = out_q;
        `REG_HIZ:      rd_mux = hiz_q;
        `REG_DFLT:     rd_mux = dflt_q;
        `REG_PULL_EN:  rd_mux = pen_q;
        `REG_PULL_SEL: rd_mux = psel_q;
        `REG_INPUT:    rd_mux = in_stat;
        `REG_MASK:     rd_mux = mask_q;
        `REG_STATUS:   rd_mux = status;
        default:       rd_mux = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // a data byte lands only at the rising edge of its own ack clock,
  // so a stop part way through a byte leaves earlier bytes intact
  wire wr_en = (ph_q == PH_WDATA) & scl_r & (cnt_q == `ACK_SLOT) & ~start & ~stop;

  always @(posedge clk) begin
    if (rst) begin
      dir_q  <= `RST_DIR; // RULE1
      out_q  <= `RST_OUT;
      hiz_q  <= `RST_HIZ;
      dflt_q <= `RST_DFLT;
      pen_q  <= `RST_PULL_EN;
      psel_q <= `RST_PULL_SEL;
      mask_q <= `RST_MASK;
    end else if (ce && wr_en) begin // RULE16 RULE17
      // input and status registers ignore writes
      case (cmd_q)
        `REG_DIR:      dir_q  <= sh_q;
        `REG_OUT:      out_q  <= sh_q;
        `REG_HIZ:      hiz_q  <= sh_q;
        `REG_DFLT:     dflt_q <= sh_q;
        `REG_PULL_EN:  pen_q  <= sh_q;
        `REG_PULL_SEL: psel_q <= sh_q;
        `REG_MASK:     mask_q <= sh_q;
        default:       mask_q <= mask_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // port pin outputs, registered
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      gpio_o   <= `RST_OUT;
      gpio_oe  <= {WIDTH{1'b0}};
      pull_en  <= `RST_PULL_EN;
      pull_sel <= `RST_PULL_SEL;
      sda_o    <= 1'b0;
      int_o    <= 1'b0;
    end else if (ce) begin
      gpio_o   <= out_q;
      gpio_oe  <= dir_q & ~hiz_q;
      pull_en  <= pen_q;
      pull_sel <= psel_q;
      sda_o    <= 1'b0;
      int_o    <= 1'b0; // RULE12
    end
  end

  // ----------------------------------------------------------------
  // bus state machine
  // ----------------------------------------------------------------
  // bits are taken on scl rise, sda is changed on scl fall; cnt_q is
  // the bit slot, with slot 8 being the acknowledge
  always @(posedge clk) begin
    if (rst) begin
      ph_q    <= PH_IDLE; // RULE1
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      tx_q    <= 8'h00;
      rw_q    <= 1'b0;
      nack_q  <= 1'b0;
      rd_st_q <= 1'b0;
      cmd_q   <= `RST_CMD;
      snap_q  <= {WIDTH{1'b0}};
      clrb_q  <= {WIDTH{1'b0}};
      clr_q   <= 1'b0;
      sda_oe  <= 1'b0;
    end else if (ce) begin
      clr_q <= 1'b0;
      if (start) begin
        // a repeated start keeps cmd_q, so plain address reads repeat
        ph_q   <= PH_ADDR; // RULE18
        // the clock fall that ends the start wraps this to slot 0, so
        // that fall is not counted as a bit of the address
        cnt_q  <= 4'hF;
        sda_oe <= 1'b0;
      end else if (stop) begin
        ph_q   <= PH_IDLE; // RULE17
        sda_oe <= 1'b0;
      end else if (ph_q != PH_IDLE) begin
        if (scl_r) begin
          if (cnt_q != `ACK_SLOT) begin
            sh_q <= {sh_q[6:0], sda_s};
          end else begin
            case (ph_q)
              PH_ADDR: begin
                if (rw_q) begin
                  // data and status snapshot taken at address ack
                  tx_q    <= rd_mux(cmd_q); // RULE7 RULE15
                  snap_q  <= status;
                  rd_st_q <= (cmd_q == `REG_STATUS);
                end
              end
              PH_CMD: begin
                cmd_q <= sh_q; // RULE13
              end
              PH_RDATA: begin
                nack_q <= sda_s;
                // only bits that were read out are cleared, so an event
                // after the capture survives into the next read
                if (rd_st_q) begin
                  clr_q  <= 1'b1; // RULE5 RULE8
                  clrb_q <= snap_q;
                end
                if (!sda_s) begin
                  tx_q   <= rd_mux(cmd_q);
                  snap_q <= status;
                end
              end
              default: begin
                nack_q <= nack_q;
              end
            endcase
          end
        end else if (scl_f) begin
          if (cnt_q != `ACK_SLOT) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == `LAST_DATA_BIT) begin
              case (ph_q)
                PH_ADDR: begin
                  if (sh_q[7:1] == my_addr) begin
                    sda_oe <= 1'b1; // RULE21
                    rw_q   <= sh_q[0]; // RULE13 RULE15
                  end else begin
                    // foreign target: drop out until the next start
                    ph_q <= PH_IDLE; // RULE9 RULE21
                  end
                end
                PH_CMD: begin
                  sda_oe <= 1'b1;
                end
                PH_WDATA: begin
                  sda_oe <= 1'b1; // RULE14
                end
                PH_RDATA: begin
                  sda_oe <= 1'b0;
                end
                default: begin
                  sda_oe <= 1'b0;
                end
              endcase
            end else if (ph_q == PH_RDATA) begin
              // shift out the next bit, open drain: drive only zeros
              tx_q   <= {tx_q[6:0], 1'b0};
              sda_oe <= ~tx_q[6];
            end
          end else begin
            cnt_q  <= 4'h0;
            sda_oe <= 1'b0;
            case (ph_q)
              PH_ADDR: begin
                if (rw_q) begin
                  ph_q   <= PH_RDATA;
                  sda_oe <= ~tx_q[7];
                end else begin
                  ph_q <= PH_CMD;
                end
              end
              PH_CMD: begin
                // no limit on the data bytes that follow
                ph_q <= PH_WDATA; // RULE14
              end
              PH_RDATA: begin
                if (nack_q) begin
                  ph_q <= PH_IDLE;
                end else begin
                  sda_oe <= ~tx_q[7];
                end
              end
              default: begin
                ph_q <= ph_q;
              end
            endcase
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt latch
  // ----------------------------------------------------------------
  // the latch sees only pin levels, this port's registers and its clear, so
  // traffic for other targets cannot reach it
  irq_latch #(
    .WIDTH   (WIDTH),
    .DLY_CYC (DLY_CYC)
  ) u_irq (
    .clk      (clk),
    .ce       (ce),
    .rst      (rst),
    .pin_in   (gpio_s),
    .dir_out  (dir_q),
    .dflt     (dflt_q),
    .mask     (mask_q),
    .clr      (clr_q),
    .clr_bits (clrb_q),
    .status_q (status),
    .int_oe_q (int_oe)
  );

endmodule // io_expander_port

// *** io_expander_port_asserts.sv ***
// assertion checker bound to the expander host port
`include "io_expander_consts.vh"
module io_expander_port_asserts #(
  parameter WIDTH   = 8,
  parameter DLY_CYC = 4
) (
  input wire logic             clk,
  input wire logic             sys_rst,
  input wire logic             rst_pin_n,
  input wire logic             scl_i,
  input wire logic             sda_oe,
  input wire logic [WIDTH-1:0] gpio_o,
  input wire logic [WIDTH-1:0] gpio_oe,
  input wire logic [WIDTH-1:0] pull_en,
  input wire logic [WIDTH-1:0] pull_sel,
  input wire logic             int_o,
  input wire logic             int_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // helper ages, saturating so a long idle never wraps into range
  // ----------------------------------------------------------------
  logic [3:0] scl_age_q;
  logic [3:0] rst_age_q;
  logic       dflt_ok;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_age_q <= 4'hF;
      rst_age_q <= 4'hF;
    end else begin
      scl_age_q <= scl_i ? 4'h0 : scl_age_q + {3'h0, scl_age_q != 4'hF};
      rst_age_q <= !rst_pin_n ? 4'h0 : rst_age_q + {3'h0, rst_age_q != 4'hF};
    end
  end
  // every register-driven pin at its reset value
  assign dflt_ok = gpio_o == `RST_OUT && gpio_oe == (`RST_DIR & ~`RST_HIZ)
                   && pull_en == `RST_PULL_EN && pull_sel == `RST_PULL_SEL
                   && !int_oe && !sda_oe;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_sys_dflt;
    $fell(sys_rst) |-> dflt_ok;
  endproperty
  a_sys_dflt: assert property (p_sys_dflt) else $error("pins off default after reset");
  property p_pin_dflt;
    !rst_pin_n [*4] |=> dflt_ok;
  endproperty
  a_pin_dflt: assert property (p_pin_dflt) else $error("reset pin did not restore");
  property p_pin_quiet;
    !rst_pin_n [*6] |-> !sda_oe && $stable({gpio_o, gpio_oe, pull_en, pull_sel});
  endproperty
  a_pin_quiet: assert property (p_pin_quiet) else $error("bus acted in reset");
  property p_int_od;
    int_oe |-> !int_o;
  endproperty
  a_int_od: assert property (p_int_od) else $error("interrupt drives high");
  property p_int_dly;
    $rose(int_oe) |-> !$past(int_oe, DLY_CYC - 1);
  endproperty
  a_int_dly: assert property (p_int_dly) else $error("interrupt too early");
  // a clear only follows a bus clock rise or the reset pin
  property p_int_clr;
    $fell(int_oe) |-> scl_age_q < 4'hA || rst_age_q < 4'h8;
  endproperty
  a_int_clr: assert property (p_int_clr) else $error("interrupt fell unprompted");
  property p_sda_hold;
    scl_i [*3] |-> $stable(sda_oe);
  endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("data moved in clock high");
  property p_commit;
    $changed({gpio_o, gpio_oe, pull_en, pull_sel}) |-> scl_age_q < 4'h8 || rst_age_q < 4'h8;
  endproperty
  a_commit: assert property (p_commit) else $error("register changed off ack");
  c_int: cover property ($rose(int_oe));
  c_ack: cover property ($rose(sda_oe));
  c_pin: cover property (!rst_pin_n [*4]);
endmodule // io_expander_port_asserts

bind io_expander_port io_expander_port_asserts #(.WIDTH(WIDTH), .DLY_CYC(DLY_CYC)) chk_u (
  .clk, .sys_rst, .rst_pin_n, .scl_i, .sda_oe, .gpio_o, .gpio_oe, .pull_en, .pull_sel,
  .int_o, .int_oe
);

// *** irq_latch.v ***
// latched interrupt status and open-drain request for the expander port
`include "io_expander_consts.vh"

module irq_latch #(
  parameter WIDTH   = 8,
  parameter DLY_CYC = `IRQ_VALID_CYC
) (
  input  wire             clk,
  input  wire             ce,
  input  wire             rst,
  input  wire [WIDTH-1:0] pin_in,
  input  wire [WIDTH-1:0] dir_out,
  input  wire [WIDTH-1:0] dflt,
  input  wire [WIDTH-1:0] mask,
  input  wire             clr,
  input  wire [WIDTH-1:0] clr_bits,
  output reg  [WIDTH-1:0] status_q,
  output reg              int_oe_q
);

  reg  [WIDTH-1:0] armed_q;
  reg  [15:0]      dly_q;
  wire [WIDTH-1:0] is_in  = ~dir_out;
  wire [WIDTH-1:0] off    = pin_in ^ dflt;
  // output pins never set a bit; a bit re-arms at the default level or while set as an output
  wire [WIDTH-1:0] set    = armed_q & is_in & off; // RULE4 RULE10 RULE19
  wire             pend   = |(status_q & ~mask & is_in); // RULE20

  // ----------------------------------------------------------------
  // sticky status: a set in the clearing cycle wins over the clear
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      status_q <= `RST_STATUS;
      armed_q  <= {WIDTH{1'b0}};
    end else if (ce) begin
      status_q <= (status_q & ~(clr ? clr_bits : {WIDTH{1'b0}})) | set; // RULE5 RULE8
      armed_q  <= (armed_q & ~set) | (is_in & ~off) | dir_out; // RULE6 RULE11
    end
  end

  // ----------------------------------------------------------------
  // request goes valid a fixed delay after it becomes pending
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      dly_q    <= 16'h0000;
      int_oe_q <= 1'b0;
    end else if (ce) begin
      if (!pend) begin
        dly_q    <= 16'h0000;
        int_oe_q <= 1'b0;
      end else if (dly_q < DLY_CYC[15:0] - 16'h0001) begin
        dly_q    <= dly_q + 16'h0001;
      end else begin
        int_oe_q <= 1'b1; // RULE4 RULE12
      end
    end
  end

endmodule // irq_latch
